// >>> rtl/pdmd_top.sv
// top: power-down mode decoder with register port
// Contract
// - four separate software power-down bits
// - pin high ignores all but pll bit
// - pin low: outputs follow software bits
// - pin high, select clear: fast recovery
// - pin high, select set: full power-down
// - all power-down signals active high
// - fast recovery keeps dac and input clock up; pll follows its bit
//
// Local design decisions: the address-and-strobe port and the placing of the registers.
`timescale 1ns/1ps
module pdmd_top (
	input  wire logic       core_clk_in,
	input  wire logic       srst_in,
	input  wire logic       external_powerdown_pin_in,
	input  wire logic [3:0] reg_addr_in,
	input  wire logic [7:0] reg_wdata_in,
	input  wire logic       reg_wr_in,
	input  wire logic       reg_rd_in,
	output logic      [7:0] reg_rdata_out,
	output logic            digital_pd_out,
	output logic            dac_pd_out,
	output logic            input_clock_pd_out,
	output logic            pll_pd_out
);
	import pdmd_pkg::*;

	logic [7:0]  cfg_reg;
	logic [7:0]  rdata_reg;
	logic [7:0]  rdata_next;
	logic        pin_sync;
	logic        dig_d;
	logic        dac_d;
	logic        inclk_d;
	logic        pll_d;
	pdmd_mode_e  mode;
	logic        dig_reg;
	logic        dac_reg;
	logic        inclk_reg;
	logic        pll_reg;
	pdmd_cfg_if  cfg_bus ();

	// -----------------------------------------------------------
	// config register, reset to zero so device powers up active
	// -----------------------------------------------------------
	always_ff @(posedge core_clk_in) begin
		if (srst_in) begin
			cfg_reg <= PDMD_CFG_RESET;
		end else if (reg_wr_in && reg_addr_in == PDMD_ADDR_CFG) begin
			cfg_reg <= reg_wdata_in & PDMD_CFG_MASK;
		end
	end

	// four independent bits plus the full select, active high
	assign cfg_bus.digital_powerdown_bit     = cfg_reg[PDMD_BIT_DIGITAL];
	assign cfg_bus.pll_powerdown_bit         = cfg_reg[PDMD_BIT_PLL];
	assign cfg_bus.dac_powerdown_bit         = cfg_reg[PDMD_BIT_DAC];
	assign cfg_bus.input_clock_powerdown_bit = cfg_reg[PDMD_BIT_INCLK];
	assign cfg_bus.full_powerdown_select     = cfg_reg[PDMD_BIT_FULLSEL];

	// -----------------------------------------------------------
	// pin crossing and decode
	// -----------------------------------------------------------
	pdmd_sync u_sync (
		.core_clk_in (core_clk_in),
		.srst_in     (srst_in),
		.async_in    (external_powerdown_pin_in),
		.sync_out    (pin_sync)
	);

	pdmd_decode u_decode (
		.pin_sync_in    (pin_sync),
		.cfg            (cfg_bus),
		.mode_out       (mode),
		.digital_pd_out (dig_d),
		.dac_pd_out     (dac_d),
		.inclk_pd_out   (inclk_d),
		.pll_pd_out     (pll_d)
	);

	// -----------------------------------------------------------
	// registered outputs: glitch free enables to analog section
	// -----------------------------------------------------------
	always_ff @(posedge core_clk_in) begin
		if (srst_in) begin
			dig_reg   <= 1'b0;
			dac_reg   <= 1'b0;
			inclk_reg <= 1'b0;
			pll_reg   <= 1'b0;
		end else begin
			dig_reg   <= dig_d;
			dac_reg   <= dac_d;
			inclk_reg <= inclk_d;
			pll_reg   <= pll_d;
		end
	end
	assign digital_pd_out     = dig_reg;
	assign dac_pd_out         = dac_reg;
	assign input_clock_pd_out = inclk_reg;
	assign pll_pd_out         = pll_reg;

	// -----------------------------------------------------------
	// read mux; unmapped addresses return zero
	// -----------------------------------------------------------
	always_comb begin
		rdata_next = 8'h00;
		if (reg_rd_in) begin
			case (reg_addr_in)
				PDMD_ADDR_CFG: begin
					rdata_next = cfg_reg;
				end
				PDMD_ADDR_STATUS: begin
					rdata_next[PDMD_ST_DIGITAL] = dig_reg;
					rdata_next[PDMD_ST_DAC]     = dac_reg;
					rdata_next[PDMD_ST_INCLK]   = inclk_reg;
					rdata_next[PDMD_ST_PLL]     = pll_reg;
					rdata_next[PDMD_ST_PIN]     = pin_sync;
					rdata_next[PDMD_ST_MODE_LO +: 2] = mode;
				end
				default: begin
					rdata_next = 8'h00;
				end
			endcase
		end
	end

	// read data valid only in the cycle after the strobe
	always_ff @(posedge core_clk_in) begin
		if (srst_in) begin
			rdata_reg <= 8'h00;
		end else begin
			rdata_reg <= rdata_next;
		end
	end
	assign reg_rdata_out = rdata_reg;
endmodule : pdmd_top

// >>> include/pdmd_pkg.sv
// package: constants for the power-down mode decoder
package pdmd_pkg;
	// -----------------------------------------------------------
	// register map (word index over the plain register port)
	// -----------------------------------------------------------
	localparam logic [3:0] PDMD_ADDR_CFG    = 4'h0;
	localparam logic [3:0] PDMD_ADDR_STATUS = 4'h1;
	// -----------------------------------------------------------
	// field positions inside the config word (bits 7:3)
	// -----------------------------------------------------------
	localparam int PDMD_BIT_DIGITAL  = 7;
	localparam int PDMD_BIT_PLL      = 6;
	localparam int PDMD_BIT_DAC      = 5;
	localparam int PDMD_BIT_INCLK    = 4;
	localparam int PDMD_BIT_FULLSEL  = 3;
	localparam logic [7:0] PDMD_CFG_MASK  = 8'hF8;
	localparam logic [7:0] PDMD_CFG_RESET = 8'h00;
	// status word positions
	localparam int PDMD_ST_DIGITAL = 0;
	localparam int PDMD_ST_DAC     = 1;
	localparam int PDMD_ST_INCLK   = 2;
	localparam int PDMD_ST_PLL     = 3;
	localparam int PDMD_ST_PIN     = 4;
	localparam int PDMD_ST_MODE_LO = 5;
	// synchroniser depth
	localparam int PDMD_SYNC_STAGES = 2;
	typedef enum logic [1:0] {
		PDMD_MODE_SOFTWARE,
		PDMD_MODE_FAST_RECOVERY,
		PDMD_MODE_FULL
	} pdmd_mode_e;
endpackage : pdmd_pkg

// >>> include/pdmd_cfg_if.sv
// interface: software config bits passed from top to decoder
`timescale 1ns/1ps
interface pdmd_cfg_if;
	logic digital_powerdown_bit;
	logic pll_powerdown_bit;
	logic dac_powerdown_bit;
	logic input_clock_powerdown_bit;
	logic full_powerdown_select;
	modport src (
		output digital_powerdown_bit,
		output pll_powerdown_bit,
		output dac_powerdown_bit,
		output input_clock_powerdown_bit,
		output full_powerdown_select
	);
	modport dst (
		input digital_powerdown_bit,
		input pll_powerdown_bit,
		input dac_powerdown_bit,
		input input_clock_powerdown_bit,
		input full_powerdown_select
	);
endinterface : pdmd_cfg_if

// >>> rtl/pdmd_sync.sv
// two flop synchroniser for the external power-down pin
`timescale 1ns/1ps
module pdmd_sync (
	input  wire logic core_clk_in,
	input  wire logic srst_in,
	input  wire logic async_in,
	output logic      sync_out
);
	import pdmd_pkg::*;
	logic meta_reg;
	logic sync_reg;
	// -----------------------------------------------------------
	// stage one feeds only stage two, to contain metastability
	// -----------------------------------------------------------
	always_ff @(posedge core_clk_in) begin
		if (srst_in) begin
			meta_reg <= 1'b0;
			sync_reg <= 1'b0;
		end else begin
			meta_reg <= async_in;
			sync_reg <= meta_reg;
		end
	end
	assign sync_out = sync_reg;
endmodule : pdmd_sync

// >>> rtl/pdmd_decode.sv
// combinational mode decode of pin level and config bits
`timescale 1ns/1ps
module pdmd_decode (
	input  wire logic          pin_sync_in,
	pdmd_cfg_if.dst            cfg,
	output pdmd_pkg::pdmd_mode_e mode_out,
	output logic              digital_pd_out,
	output logic              dac_pd_out,
	output logic              inclk_pd_out,
	output logic              pll_pd_out
);
	import pdmd_pkg::*;
	// -----------------------------------------------------------
	// decode: pin high overrides the individual bits except the pll bit
	// -----------------------------------------------------------
	always_comb begin
		pll_pd_out = cfg.pll_powerdown_bit;
		if (!pin_sync_in) begin
			// software control, select bit is a don't care
			mode_out       = PDMD_MODE_SOFTWARE;
			digital_pd_out = cfg.digital_powerdown_bit;
			dac_pd_out     = cfg.dac_powerdown_bit;
			inclk_pd_out   = cfg.input_clock_powerdown_bit;
		end else if (!cfg.full_powerdown_select) begin
			// dac and clock input stay up for speed
			mode_out       = PDMD_MODE_FAST_RECOVERY;
			digital_pd_out = 1'b1;
			dac_pd_out     = 1'b0;
			inclk_pd_out   = 1'b0;
		end else begin
			mode_out       = PDMD_MODE_FULL;
			digital_pd_out = 1'b1;
			dac_pd_out     = 1'b1;
			inclk_pd_out   = 1'b1;
		end
	end
endmodule : pdmd_decode

// >>> test/pdmd_ctl_model.sv
// partner: system controller driving the power-down pin
`timescale 1ns/1ps
module pdmd_ctl_model (
	input  wire logic core_clk_in,
	input  wire logic level_in,
	output logic      pin_out
);
	// pin moves 3 ns after an edge, so its phase is not the core's
	initial pin_out = 1'b0;
	always @(posedge core_clk_in) begin
		pin_out <= #3 level_in;
	end
endmodule : pdmd_ctl_model

// >>> test/pdmd_chk_props.sv
// checker: port properties of the power-down decoder
`timescale 1ns/1ps
module pdmd_chk (
	input wire logic       core_clk_in,
	input wire logic       srst_in,
	input wire logic       external_powerdown_pin_in,
	input wire logic [3:0] reg_addr_in,
	input wire logic [7:0] reg_wdata_in,
	input wire logic       reg_wr_in,
	input wire logic       reg_rd_in,
	input wire logic [7:0] reg_rdata_out,
	input wire logic       digital_pd_out,
	input wire logic       dac_pd_out,
	input wire logic       input_clock_pd_out,
	input wire logic       pll_pd_out
);
	import pdmd_pkg::*;
	logic [7:0] cfg_reg;
	logic [7:0] cfg_d_reg;
	logic [1:0] arm_reg;
	wire        armed = arm_reg == 2'h3;
	default clocking @(posedge core_clk_in); endclocking
	default disable iff (srst_in);
	// shadow config; cfg_d_reg lines up with the output register
	always_ff @(posedge core_clk_in) begin
		if (srst_in) cfg_reg <= 8'h00;
		else if (reg_wr_in && reg_addr_in == PDMD_ADDR_CFG)
			cfg_reg <= reg_wdata_in & PDMD_CFG_MASK;
		cfg_d_reg <= srst_in ? 8'h00 : cfg_reg;
	end
	// pin needs three edges to reach the outputs after reset
	always_ff @(posedge core_clk_in) begin
		if (srst_in) arm_reg <= 2'h0;
		else if (!armed) arm_reg <= arm_reg + 2'h1;
	end
	pll_follow_a: assert property (armed |-> pll_pd_out == cfg_d_reg[6])
		else $error("pll output wrong");
	soft_mode_a: assert property (armed
		&& !$past(external_powerdown_pin_in, 3)
		|-> {digital_pd_out, dac_pd_out, input_clock_pd_out}
		== {cfg_d_reg[7], cfg_d_reg[5], cfg_d_reg[4]}) else $error("soft wrong");
	fast_recovery_a: assert property (armed && !cfg_d_reg[3]
		&& $past(external_powerdown_pin_in, 3) |-> {digital_pd_out,
		dac_pd_out, input_clock_pd_out} == 3'h4) else $error("fast wrong");
	full_pd_a: assert property (armed && cfg_d_reg[3]
		&& $past(external_powerdown_pin_in, 3) |-> {digital_pd_out,
		dac_pd_out, input_clock_pd_out} == 3'h7) else $error("full wrong");
	reset_clear_a: assert property ($fell(srst_in) |-> {reg_rdata_out,
		digital_pd_out, dac_pd_out, input_clock_pd_out, pll_pd_out} == 12'h0)
		else $error("not clear after reset");
	cfg_read_a: assert property (reg_rd_in && reg_addr_in == PDMD_ADDR_CFG
		|=> reg_rdata_out == cfg_d_reg) else $error("cfg read wrong");
	rdata_idle_a: assert property ((!reg_rd_in || reg_addr_in > 4'h1)
		|=> reg_rdata_out == 8'h00) else $error("rdata not zero");
	status_read_a: assert property (armed && reg_rd_in && reg_addr_in == 4'h1
		|=> reg_rdata_out[4:0] == {$past(external_powerdown_pin_in, 3),
		$past(pll_pd_out), $past(input_clock_pd_out), $past(dac_pd_out),
		$past(digital_pd_out)}) else $error("status wrong");
endmodule : pdmd_chk
bind pdmd_top pdmd_chk i_pdmd_chk (.core_clk_in, .srst_in,
	.external_powerdown_pin_in, .reg_addr_in, .reg_wdata_in, .reg_wr_in,
	.reg_rd_in, .reg_rdata_out, .digital_pd_out, .dac_pd_out,
	.input_clock_pd_out, .pll_pd_out);

// >>> test/tb.sv
// testbench: corner and random runs of the power-down decoder
`timescale 1ns/1ps
module tb;
	import pdmd_pkg::*;
	logic       clk = 1'b0;
	logic       srst = 1'b1;
	logic       lvl = 1'b0;
	logic       pin;
	logic [3:0] addr = 4'h0;
	logic [7:0] wdata = 8'h00;
	logic       wr = 1'b0;
	logic       rd = 1'b0;
	logic [7:0] rdata;
	wire  [3:0] pd;
	int         mismatches = 0;
	int         checked = 0;
	int         seed = 55892;
	int         cyc = 0;
	always #10 clk = ~clk;
	pdmd_ctl_model i_pdmd_ctl_model (.core_clk_in(clk), .level_in(lvl),
		.pin_out(pin));
	pdmd_top i_pdmd_top (.core_clk_in(clk), .srst_in(srst),
		.external_powerdown_pin_in(pin), .reg_addr_in(addr),
		.reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd),
		.reg_rdata_out(rdata), .digital_pd_out(pd[0]), .dac_pd_out(pd[1]),
		.input_clock_pd_out(pd[2]), .pll_pd_out(pd[3]));
	// pin high overrides every software bit except the pll one
	function automatic logic [3:0] exp_pd(input logic p, input logic [7:0] c);
		return {c[6], p ? c[3] : c[4], p ? c[3] : c[5], p | c[7]};
	endfunction : exp_pd
	function automatic logic [7:0] exp_st(input logic p, input logic [7:0] c);
		return {1'b0, p ? (c[3] ? 2'h2 : 2'h1) : 2'h0, p, exp_pd(p, c)};
	endfunction : exp_st
	task automatic cmp(input string n, input logic [7:0] e, input logic [7:0] g);
		checked++;
		if (g !== e) begin
			mismatches++;
			$display("unexpected %s expected %h seen %h", n, e, g);
		end
	endtask : cmp
	task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk);
		wr <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge clk);
		wr <= 1'b0;
	endtask : wr_reg
	task automatic rd_reg(input logic [3:0] a, input logic [7:0] e);
		@(posedge clk);
		rd <= 1'b1;
		addr <= a;
		@(posedge clk);
		rd <= 1'b0;
		#1 cmp("rdata", e, rdata);
	endtask : rd_reg
	// set pin and config, let the pin cross, then check every output
	task automatic step(input logic p, input logic [7:0] d);
		logic [7:0] c;
		logic [3:0] a;
		c = d & PDMD_CFG_MASK;
		a = 4'h2 | 4'($random(seed));
		@(posedge clk);
		lvl <= p;
		wr_reg(PDMD_ADDR_CFG, d);
		repeat (4) @(posedge clk);
		#1 cmp("pd", {4'h0, exp_pd(p, c)}, {4'h0, pd});
		wr_reg(a, ~d);
		rd_reg(PDMD_ADDR_CFG, c);
		rd_reg(PDMD_ADDR_STATUS, exp_st(p, c));
		rd_reg(a, 8'h00);
	endtask : step
	task automatic complete_run;
		if (mismatches == 0 && checked > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask : complete_run
	// cycle ceiling; the run needs about 1600 cycles
	always @(posedge clk) begin
		cyc++;
		if (cyc == 8000) begin
			mismatches++;
			complete_run();
		end
	end
	initial begin
		repeat (4) @(posedge clk);
		srst <= 1'b0;
		@(posedge clk);
		#1 cmp("pd", 8'h00, {4'h0, pd});
		for (int i = 0; i < 64; i++)
			step(i[5], {i[4:0], 3'($random(seed))});
		repeat (40) step(1'($random(seed)), 8'($random(seed)));
		// mid-run reset with the pin high: the synchroniser must flush too
		@(posedge clk);
		lvl <= 1'b1;
		srst <= 1'b1;
		repeat (4) @(posedge clk);
		srst <= 1'b0;
		@(posedge clk);
		#1 cmp("pd", 8'h00, {4'h0, pd});
		rd_reg(PDMD_ADDR_CFG, PDMD_CFG_RESET);
		step(1'b1, 8'h00);
		complete_run();
	end
endmodule : tb
